/* hdl/tmr8_pkg.sv */
// Purpose: Constants for the 8-bit timer/counter with one compare unit
// Assumes: 32-bit AXI4-Lite register slave, one word per register
// Notes: All offsets are byte addresses
`default_nettype none
package tmr8_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] TMR8_CTRL_OFF = 5'h00;
  localparam logic [4:0] TMR8_COUNT_OFF = 5'h04;
  localparam logic [4:0] TMR8_CMP_OFF = 5'h08;
  localparam logic [4:0] TMR8_FLAGS_OFF = 5'h0C;
  localparam logic [4:0] TMR8_IRQEN_OFF = 5'h10;
  // ==========================================================
  // Control field positions
  localparam int TMR8_CS_LSB = 0;
  localparam int TMR8_CS_MSB = 2;
  localparam int TMR8_WGM_LSB = 3;
  localparam int TMR8_WGM_MSB = 4;
  localparam int TMR8_COM_LSB = 5;
  localparam int TMR8_COM_MSB = 6;
  localparam int TMR8_FORCE_BIT = 7;
  // Flag and enable bit positions
  localparam int TMR8_CMP_BIT = 0;
  localparam int TMR8_OVF_BIT = 1;
  // ==========================================================
  // Reset values and count limits
  localparam logic [7:0] TMR8_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR8_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR8_CMP_RST = 8'h00;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hFF;
  localparam logic [7:0] TMR8_ONE = 8'h01;
  localparam logic [2:0] TMR8_CS_STOP = 3'h0;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] TMR8_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR8_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Waveform modes
  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL = 2'b00,
    TMR8_WGM_PHASE = 2'b01,
    TMR8_WGM_CLEAR = 2'b10,
    TMR8_WGM_FAST = 2'b11
  } tmr8_wgm_t;
  // Compare output modes
  typedef enum logic [1:0] {
    TMR8_COM_OFF = 2'b00,
    TMR8_COM_TOGGLE = 2'b01,
    TMR8_COM_CLEAR = 2'b10,
    TMR8_COM_SET = 2'b11
  } tmr8_com_t;
endpackage : tmr8_pkg
`default_nettype wire

/* hdl/tmr8_timer.sv */
// Purpose: 8-bit timer/counter with compare unit and AXI4-Lite registers
// Assumes: timer_tick is a one-cycle enable from an outside prescaler
// Notes: Counter, compare and flags are 8 bits in the low byte lane
//
// Operation
// [R1] Clock select zero stops the counter
// [R2] Each tick steps, clears, per mode
// [R3] Counter readable, writable; write beats counting
// [R4] Waveform mode sets sequence; output mode doesn't
// [R5] Equality sets compare flag at next tick
// [R6] Request irq when flag, enable, global set
// [R7] Writing one clears compare flag
// [R8] PWM modes double buffer the compare value
// [R9] Software reaches buffer or working copy
// [R10] Force strobe acts like match, non-PWM only
// [R11] Counter write blocks matches next tick
// [R12] Output register holds over modes; reset zero
// [R13] Output mode change acts at next match
// [R14] Output mode nonzero overrides port data
// [R15] Override independent of waveform mode
// [R16] Output mode zero does nothing at match
// [R17] Set/clear/toggle, or inverted/non-inverted PWM
// [R18] Normal mode counts up, wraps FF to 00
// [R19] Overflow flag set on wrap, ack clears
// [R20] Software sets output before enabling pin
// [R21] Modes: normal 0, phase 1, clear 2, fast 3
// [R22] Bottom is 00, max FF, top per mode
// [R23] Force strobe is a pulse, ignored in PWM
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module tmr8_timer #(
  parameter int ADDR_W = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_tick,
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic port_data,
  input wire logic output_pin_direction_bit,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic pin_out,
  output logic pin_oe
);
  import tmr8_pkg::*;

  if (ADDR_W < 5) begin : g_addr_chk
    $error("ADDR_W must be at least 5");
  end

  // ==========================================================
  // Register bus
  logic aw_got_r;
  logic w_got_r;
  logic [4:0] waddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_do;
  logic wr_ok;
  logic rd_ok;
  logic [4:0] raddr;
  logic [7:0] rd_byte;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  assign raddr = s_axi_araddr[4:0];

  always_comb begin
    wr_ok = 1'b0;
    if (waddr_r == TMR8_CTRL_OFF || waddr_r == TMR8_COUNT_OFF ||
        waddr_r == TMR8_CMP_OFF || waddr_r == TMR8_FLAGS_OFF ||
        waddr_r == TMR8_IRQEN_OFF) begin
      wr_ok = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_got_r <= 1'b0;
      waddr_r <= 5'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      waddr_r <= s_axi_awaddr[4:0];
    end else if (wr_do) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_got_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wstrb_r <= s_axi_wstrb[0];
    end else if (wr_do) begin
      w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= TMR8_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Control and state registers
  logic [2:0] cs_r;
  tmr8_wgm_t wgm_r;
  tmr8_com_t com_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] cmp_work_r;
  logic [7:0] cmp_buf_r;
  logic cmp_flag_r;
  logic ovf_flag_r;
  logic cmp_en_r;
  logic ovf_en_r;
  logic down_r;
  logic block_r;
  logic oc_r;
  logic lane;
  logic ctrl_wr;
  logic cnt_wr;
  logic cmp_wr;
  logic flag_wr;
  logic tick;
  logic pwm;
  logic match;
  logic match_evt;
  logic force_p;
  logic cmp_set;
  logic ovf_set;
  logic cmp_load;
  tmr8_com_t force_com;

  assign lane = wr_do && wstrb_r;
  assign ctrl_wr = lane && waddr_r == TMR8_CTRL_OFF;
  assign cnt_wr = lane && waddr_r == TMR8_COUNT_OFF;
  assign cmp_wr = lane && waddr_r == TMR8_CMP_OFF;
  assign flag_wr = lane && waddr_r == TMR8_FLAGS_OFF;
  assign tick = timer_tick && cs_r != TMR8_CS_STOP; // [R1]
  assign pwm = wgm_r == TMR8_WGM_PHASE || wgm_r == TMR8_WGM_FAST;
  assign match = count_r == cmp_work_r; // [R5]
  assign match_evt = tick && match && !block_r; // [R11]
  assign force_com = tmr8_com_t'(wdata_r[TMR8_COM_MSB:TMR8_COM_LSB]);
  // Mode of the same write decides; PWM modes have the low mode bit set
  assign force_p = ctrl_wr && wdata_r[TMR8_FORCE_BIT] &&
                   !wdata_r[TMR8_WGM_LSB]; // [R23] [R10]

  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_r <= TMR8_CTRL_RST[TMR8_CS_MSB:TMR8_CS_LSB];
      wgm_r <= TMR8_WGM_NORMAL;
      com_r <= TMR8_COM_OFF;
    end else if (ctrl_wr) begin
      cs_r <= wdata_r[TMR8_CS_MSB:TMR8_CS_LSB];
      wgm_r <= tmr8_wgm_t'(wdata_r[TMR8_WGM_MSB:TMR8_WGM_LSB]); // [R21]
      com_r <= force_com; // [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_en_r <= 1'b0;
      ovf_en_r <= 1'b0;
    end else if (lane && waddr_r == TMR8_IRQEN_OFF) begin
      cmp_en_r <= wdata_r[TMR8_CMP_BIT];
      ovf_en_r <= wdata_r[TMR8_OVF_BIT];
    end
  end

  // ==========================================================
  // Counter unit
  always_comb begin
    count_nxt = count_r + TMR8_ONE;
    case (wgm_r) // [R4]
      TMR8_WGM_NORMAL: count_nxt = count_r + TMR8_ONE; // [R18]
      TMR8_WGM_CLEAR: begin
        if (match_evt) begin
          count_nxt = TMR8_BOTTOM;
        end
      end
      TMR8_WGM_FAST: count_nxt = count_r + TMR8_ONE; // [R22]
      TMR8_WGM_PHASE: begin
        if (count_r == TMR8_MAX) begin
          count_nxt = count_r - TMR8_ONE;
        end else if (count_r == TMR8_BOTTOM) begin
          count_nxt = TMR8_ONE;
        end else if (down_r) begin
          count_nxt = count_r - TMR8_ONE;
        end
      end
      default: count_nxt = count_r + TMR8_ONE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r <= TMR8_COUNT_RST;
    end else if (cnt_wr) begin
      count_r <= wdata_r; // [R3]
    end else if (tick) begin
      count_r <= count_nxt; // [R2]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      down_r <= 1'b0;
    end else if (tick && wgm_r == TMR8_WGM_PHASE) begin
      if (count_r == TMR8_MAX) begin
        down_r <= 1'b1;
      end else if (count_r == TMR8_BOTTOM) begin
        down_r <= 1'b0;
      end
    end else if (wgm_r != TMR8_WGM_PHASE) begin
      down_r <= 1'b0;
    end
  end

  // Held until the next tick consumes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1; // [R11]
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ==========================================================
  // Compare value, double buffered in PWM modes
  always_comb begin
    cmp_load = 1'b0;
    if (tick && wgm_r == TMR8_WGM_FAST && count_r == TMR8_MAX) begin
      cmp_load = 1'b1;
    end
    if (tick && wgm_r == TMR8_WGM_PHASE && count_r == TMR8_MAX) begin
      cmp_load = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_buf_r <= TMR8_CMP_RST;
    end else if (cmp_wr) begin
      cmp_buf_r <= wdata_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_work_r <= TMR8_CMP_RST;
    end else if (cmp_wr && !pwm) begin
      cmp_work_r <= wdata_r; // [R8] [R9]
    end else if (pwm && cmp_load) begin
      cmp_work_r <= cmp_buf_r; // [R8]
    end
  end

  // ==========================================================
  // Flags; a set in the same cycle beats any clear
  always_comb begin
    ovf_set = 1'b0;
    if (tick && !cnt_wr) begin
      if (wgm_r == TMR8_WGM_PHASE) begin
        ovf_set = down_r && count_r == TMR8_ONE;
      end else begin
        ovf_set = count_r == TMR8_MAX && count_nxt == TMR8_BOTTOM; // [R19]
      end
    end
  end
  assign cmp_set = match_evt;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_flag_r <= 1'b0;
    end else if (cmp_set) begin
      cmp_flag_r <= 1'b1; // [R5]
    end else if (compare_irq_ack) begin
      cmp_flag_r <= 1'b0; // [R6]
    end else if (flag_wr && wdata_r[TMR8_CMP_BIT]) begin
      cmp_flag_r <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_flag_r <= 1'b1; // [R19]
    end else if (overflow_irq_ack) begin
      ovf_flag_r <= 1'b0;
    end else if (flag_wr && wdata_r[TMR8_OVF_BIT]) begin
      ovf_flag_r <= 1'b0;
    end
  end

  assign compare_irq_req = cmp_flag_r && cmp_en_r && global_irq_enable; // [R6]
  assign overflow_irq_req = ovf_flag_r && ovf_en_r && global_irq_enable;

  // ==========================================================
  // Waveform generator and compare output register
  function automatic logic act_nonpwm(input tmr8_com_t com,
                                      input logic cur);
    logic res;
    res = cur;
    case (com) // [R17] [R16]
      TMR8_COM_TOGGLE: res = !cur;
      TMR8_COM_CLEAR: res = 1'b0;
      TMR8_COM_SET: res = 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction : act_nonpwm

  always_ff @(posedge mclk) begin
    if (reset) begin
      oc_r <= 1'b0; // [R12]
    end else if (force_p) begin
      oc_r <= act_nonpwm(force_com, oc_r); // [R10]
    end else if (tick && wgm_r == TMR8_WGM_FAST && count_r == TMR8_MAX &&
                 !block_r && com_r[1]) begin
      oc_r <= !com_r[0]; // [R17]
    end else if (match_evt) begin
      case (wgm_r)
        TMR8_WGM_FAST: begin
          if (com_r == TMR8_COM_TOGGLE) begin
            oc_r <= !oc_r;
          end else if (com_r[1]) begin
            oc_r <= com_r[0];
          end
        end
        TMR8_WGM_PHASE: begin
          if (com_r[1]) begin
            oc_r <= com_r[0] ^ down_r; // [R17]
          end
        end
        default: oc_r <= act_nonpwm(com_r, oc_r); // [R13]
      endcase
    end
  end

  assign pin_out = (com_r != TMR8_COM_OFF) ? oc_r : port_data; // [R14] [R15]
  assign pin_oe = output_pin_direction_bit; // [R14]

  // ==========================================================
  // Register read path
  always_comb begin
    rd_ok = 1'b1;
    rd_byte = 8'h00;
    case (raddr)
      TMR8_CTRL_OFF: rd_byte = {1'b0, com_r, wgm_r, cs_r};
      TMR8_COUNT_OFF: rd_byte = count_r; // [R3]
      TMR8_CMP_OFF: rd_byte = pwm ? cmp_buf_r : cmp_work_r; // [R9]
      TMR8_FLAGS_OFF: rd_byte = {6'h00, ovf_flag_r, cmp_flag_r};
      TMR8_IRQEN_OFF: rd_byte = {6'h00, ovf_en_r, cmp_en_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= TMR8_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_ok ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  property p_stop;
    @(posedge mclk) disable iff (reset)
      (cs_r == TMR8_CS_STOP && !cnt_wr) |=> $stable(count_r);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved"); // [R1]

  property p_normal_step;
    @(posedge mclk) disable iff (reset)
      (tick && !cnt_wr && wgm_r == TMR8_WGM_NORMAL)
        |=> count_r == 8'($past(count_r) + 8'h01);
  endproperty
  a_normal_step: assert property (p_normal_step) // [R18]
    else $error("normal mode step wrong");

  property p_wr_prio;
    @(posedge mclk) disable iff (reset)
      cnt_wr |=> count_r == $past(wdata_r);
  endproperty
  a_wr_prio: assert property (p_wr_prio) // [R3]
    else $error("counter write lost");

  property p_flag_set;
    @(posedge mclk) disable iff (reset)
      (tick && match && !block_r) |=> cmp_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) // [R5]
    else $error("match flag not set");

  property p_w1c;
    @(posedge mclk) disable iff (reset)
      (flag_wr && wdata_r[0] && !cmp_set) |=> !cmp_flag_r;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared"); // [R7]

  property p_ack;
    @(posedge mclk) disable iff (reset)
      (compare_irq_req && compare_irq_ack && !cmp_set)
        |=> !cmp_flag_r && !compare_irq_req;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear"); // [R6]

  property p_block;
    @(posedge mclk) disable iff (reset)
      (cnt_wr && !cmp_flag_r && !cmp_set) ##1 (tick && !cnt_wr) ##1 1'b1
        |-> !cmp_flag_r;
  endproperty
  a_block: assert property (p_block) // [R11]
    else $error("match after counter write");

  property p_direct_cmp;
    @(posedge mclk) disable iff (reset)
      (cmp_wr && !pwm) |=> cmp_work_r == $past(wdata_r);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) // [R8]
    else $error("direct compare write lost");

  property p_buffered;
    @(posedge mclk) disable iff (reset)
      (pwm && !cmp_load) |=> $stable(cmp_work_r);
  endproperty
  a_buffered: assert property (p_buffered) // [R8]
    else $error("working compare moved off top");

  property p_ovf;
    @(posedge mclk) disable iff (reset)
      (tick && !cnt_wr && wgm_r == TMR8_WGM_NORMAL && count_r == 8'hFF)
        |=> ovf_flag_r && count_r == 8'h00;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // [R19]

  property p_force_noflag;
    @(posedge mclk) disable iff (reset)
      (force_p && !cmp_set && !cmp_flag_r) |=> !cmp_flag_r;
  endproperty
  a_force_noflag: assert property (p_force_noflag) // [R10]
    else $error("force set the flag");

  c_flag: cover property (@(posedge mclk) disable iff (reset) cmp_set);
  c_ovf: cover property (@(posedge mclk) disable iff (reset) ovf_set);
  c_force: cover property (@(posedge mclk) disable iff (reset) force_p);
  c_load: cover property (@(posedge mclk) disable iff (reset)
    pwm && cmp_load);
endmodule : tmr8_timer
`default_nettype wire

/* tb/test_timer8_counter_compare_unit.sv */
// Purpose: Self-checking bench for the 8-bit timer with one compare unit
// Assumes: Registers reached over AXI4-Lite, one-cycle tick pulses
// Notes: Inputs change by non-blocking assignment at rising edges
`default_nettype none
module test_timer8_counter_compare_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr8_pkg::*;

  // ==========================================================
  // Signals
  logic mclk;
  logic reset;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic timer_tick, glob_en, cmp_ack, ovf_ack, port_data, dir_bit;
  logic cmp_req, ovf_req, pin_out, pin_oe;
  int err_count;
  int n_tests;

  tmr8_timer #(.ADDR_W(5)) dut_u (
    .mclk(mclk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_tick(timer_tick), .global_irq_enable(glob_en),
    .compare_irq_ack(cmp_ack), .overflow_irq_ack(ovf_ack),
    .port_data(port_data), .output_pin_direction_bit(dir_bit),
    .compare_irq_req(cmp_req), .overflow_irq_req(ovf_req),
    .pin_out(pin_out), .pin_oe(pin_oe)
  );

  always #4 mclk = ~mclk;

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [4:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    logic a_hs, w_hs, b_hs;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge mclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge mclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic a_hs, r_hs;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge mclk);
      a_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (a_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", {30'h0, TMR8_RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd(input string nm, input logic [4:0] a,
                    input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk("rresp", {30'h0, TMR8_RESP_OKAY}, {30'h0, r});
    chk(nm, {24'h000000, e}, d);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
      @(posedge mclk);
      timer_tick <= 1'b0;
    end
  endtask : tick

  task automatic pulse_ack(input logic ovf);
    @(posedge mclk);
    if (ovf) ovf_ack <= 1'b1;
    else cmp_ack <= 1'b1;
    @(posedge mclk);
    ovf_ack <= 1'b0;
    cmp_ack <= 1'b0;
  endtask : pulse_ack

  task automatic pin(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : pin

  function automatic logic [7:0] cw(input logic [2:0] cs,
      input logic [1:0] wg, input logic [1:0] cm, input int f);
    return {f[0], cm, wg, cs};
  endfunction : cw

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd("ctrl", TMR8_CTRL_OFF, TMR8_CTRL_RST);
    rd("count", TMR8_COUNT_OFF, TMR8_COUNT_RST);
    rd("cmp", TMR8_CMP_OFF, TMR8_CMP_RST);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    axi_rd(5'h14, d, r);
    chk("bad_rresp", {30'h0, TMR8_RESP_SLVERR}, {30'h0, r});
    chk("bad_rdata", 32'h00000000, d);
    axi_wr(5'h14, 8'hFF, r);
    chk("bad_bresp", {30'h0, TMR8_RESP_SLVERR}, {30'h0, r});
    wstrb <= 4'hE;
    wr(TMR8_COUNT_OFF, 8'hFF);
    wstrb <= 4'hF;
    rd("count", TMR8_COUNT_OFF, 8'h00);
    port_data <= 1'b1;
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    pin("pin_oe", 1'b0, pin_oe);
  endtask : t_reset

  task automatic t_stop;
    wr(TMR8_CTRL_OFF, cw(TMR8_CS_STOP, TMR8_WGM_NORMAL, TMR8_COM_OFF, 0));
    wr(TMR8_COUNT_OFF, 8'h05);
    tick(3);
    rd("count", TMR8_COUNT_OFF, 8'h05);
  endtask : t_stop

  task automatic t_normal;
    wr(TMR8_IRQEN_OFF, 8'h02);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_OFF, 0));
    wr(TMR8_COUNT_OFF, 8'hFE);
    tick(1);
    rd("count", TMR8_COUNT_OFF, 8'hFF);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    tick(1);
    rd("count", TMR8_COUNT_OFF, 8'h00);
    rd("flags", TMR8_FLAGS_OFF, 8'h02);
    @(negedge mclk);
    pin("ovf_req", 1'b1, ovf_req);
    pulse_ack(1'b1);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
  endtask : t_normal

  task automatic t_match;
    wr(TMR8_IRQEN_OFF, 8'h01);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_TOGGLE, 0));
    wr(TMR8_CMP_OFF, 8'h10);
    wr(TMR8_COUNT_OFF, 8'h0F);
    tick(1);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    tick(1);
    rd("flags", TMR8_FLAGS_OFF, 8'h01);
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    pin("cmp_req", 1'b1, cmp_req);
    @(posedge mclk);
    glob_en <= 1'b0;
    @(negedge mclk);
    pin("cmp_req", 1'b0, cmp_req);
    @(posedge mclk);
    glob_en <= 1'b1;
    wr(TMR8_FLAGS_OFF, 8'h00);
    rd("flags", TMR8_FLAGS_OFF, 8'h01);
    wr(TMR8_FLAGS_OFF, 8'h01);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    wr(TMR8_COUNT_OFF, 8'h0F);
    tick(2);
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
    pulse_ack(1'b0);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
  endtask : t_match

  task automatic t_block;
    wr(TMR8_CTRL_OFF, cw(3'h0, TMR8_WGM_NORMAL, TMR8_COM_TOGGLE, 0));
    wr(TMR8_CMP_OFF, 8'h20);
    wr(TMR8_COUNT_OFF, 8'h20);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_TOGGLE, 0));
    tick(1);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
  endtask : t_block

  task automatic t_force;
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_SET, 1));
    dir_bit <= 1'b1;
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    pin("pin_oe", 1'b1, pin_oe);
    rd("flags", TMR8_FLAGS_OFF, 8'h00);
    rd("count", TMR8_COUNT_OFF, 8'h21);
    rd("ctrl", TMR8_CTRL_OFF, cw(3'h1, 2'h0, 2'h3, 0));
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_CLEAR, 1));
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_TOGGLE, 1));
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_FAST, TMR8_COM_CLEAR, 1));
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_NORMAL, TMR8_COM_OFF, 0));
    port_data <= 1'b0;
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
    wr(TMR8_COUNT_OFF, 8'h1F);
    tick(2);
    rd("flags", TMR8_FLAGS_OFF, 8'h01);
    wr(TMR8_CTRL_OFF, cw(3'h0, TMR8_WGM_NORMAL, TMR8_COM_TOGGLE, 0));
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    wr(TMR8_FLAGS_OFF, 8'h01);
  endtask : t_force

  task automatic t_buffer;
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_FAST, TMR8_COM_CLEAR, 0));
    wr(TMR8_CMP_OFF, 8'h40);
    rd("cmp", TMR8_CMP_OFF, 8'h40);
    wr(TMR8_COUNT_OFF, 8'h1F);
    tick(2);
    rd("flags", TMR8_FLAGS_OFF, 8'h01);
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
    wr(TMR8_FLAGS_OFF, 8'h01);
    wr(TMR8_COUNT_OFF, 8'hFE);
    tick(2);
    rd("count", TMR8_COUNT_OFF, 8'h00);
    @(negedge mclk);
    pin("pin_out", 1'b1, pin_out);
    wr(TMR8_COUNT_OFF, 8'h3F);
    tick(2);
    rd("flags", TMR8_FLAGS_OFF, 8'h03);
    @(negedge mclk);
    pin("pin_out", 1'b0, pin_out);
    wr(TMR8_FLAGS_OFF, 8'h03);
  endtask : t_buffer

  task automatic t_modes;
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_PHASE, TMR8_COM_OFF, 0));
    wr(TMR8_COUNT_OFF, 8'hFE);
    tick(2);
    rd("count", TMR8_COUNT_OFF, 8'hFE);
    wr(TMR8_CTRL_OFF, cw(3'h1, TMR8_WGM_CLEAR, TMR8_COM_TOGGLE, 0));
    wr(TMR8_CMP_OFF, 8'h05);
    wr(TMR8_COUNT_OFF, 8'h04);
    tick(2);
    rd("count", TMR8_COUNT_OFF, 8'h00);
  endtask : t_modes

  // ==========================================================
  // Verdict and sequencing
  task automatic conclude;
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {timer_tick, cmp_ack, ovf_ack, port_data, dir_bit} = '0;
    glob_en = 1'b1;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_stop();
    t_normal();
    t_match();
    t_block();
    t_force();
    t_buffer();
    t_modes();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude();
  end
endmodule : test_timer8_counter_compare_unit
`default_nettype wire
